/* File: common/scru_params.svh */
// strap positions, register map, reset values and timing counts
`ifndef SCRU_PARAMS_SVH
`define SCRU_PARAMS_SVH
// ==========================================
// timing
`define SCRU_CLK_MHZ 250
`define SCRU_EXT_CLK_MHZ 25
`define SCRU_EXT_CLK_HALF ((`SCRU_CLK_MHZ / `SCRU_EXT_CLK_MHZ) / 2)
`define SCRU_STRETCH_US 10000
`define SCRU_STRETCH_CYC (`SCRU_STRETCH_US * `SCRU_CLK_MHZ)
// ==========================================
// strap pin positions on the gpio bus
`define SCRU_GP_IFSEL0 0
`define SCRU_GP_IFSEL1 1
`define SCRU_GP_ANEG 2
`define SCRU_GP_ISO 3
`define SCRU_GP_SPD0 4
`define SCRU_GP_MDA3 5
`define SCRU_GP_MEMCFG 6
`define SCRU_GP_MDA4 7
`define SCRU_GP_ROLE 8
`define SCRU_GP_BOOT 10
`define SCRU_GP_SPD1 11
`define SCRU_GP_W 12
// ==========================================
// strap reset values and pulls
`define SCRU_PULL_UP 12'h577
`define SCRU_PULL_DN 12'h888
`define SCRU_STRAP_RST 12'h577
`define SCRU_DUPLEX_RST 1'b1
`define SCRU_MGMT_ADDR_RST 5'h08
// ==========================================
// register map
`define SCRU_CTRL_OFS 8'h00
`define SCRU_STAT_OFS 8'h04
`define SCRU_STRAP_OFS 8'h08
`define SCRU_CTRL_RST 2'h1
`define SCRU_CTRL_CLKEN 0
`define SCRU_CTRL_PHYRST 1
`endif

/* File: common/scru_pkg.sv */
// types shared by the strap and reset unit
package scru_pkg;
  typedef enum logic [2:0] {
    SEQ_HOLD = 3'b001,
    SEQ_STRETCH = 3'b010,
    SEQ_RUN = 3'b100
  } scru_seq_type;
endpackage : scru_pkg

/* File: rtl/scru_clk_div.sv */
// divider making the square wave for the external phy clock
`include "scru_params.svh"
module scru_clk_div
  import scru_pkg::*;
#(
  parameter int unsigned HALF = `SCRU_EXT_CLK_HALF
) (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic run_i,
  output logic clk_o
);
  localparam int unsigned CW = (HALF > 1) ? $clog2(HALF) : 1;

  if (HALF < 1) begin : g_chk
    $error("scru_clk_div: HALF must be at least 1");
  end

  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic clk_reg;
  logic clk_next;
  wire tick = (cnt_reg == CW'(HALF - 1));

  // stopped clock parks low on the next cycle, so a high phase in progress is cut short
  assign cnt_next = (!run_i || tick) ? '0 : cnt_reg + 1'b1;
  assign clk_next = run_i ? (clk_reg ^ tick) : 1'b0;

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      cnt_reg <= '0;
      clk_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      clk_reg <= clk_next;
    end
  end

  assign clk_o = clk_reg;
endmodule : scru_clk_div

/* File: rtl/scru_top.sv */
// strap capture, phy reset stretch and phy clock output with apb registers
// ==========================================
//
// Implementation choices: register access over APB and the register offsets.
`include "scru_params.svh"
module scru_top
  import scru_pkg::*;
#(
  parameter int unsigned STRETCH_CYCLES = `SCRU_STRETCH_CYC,
  parameter int unsigned CLK_HALF = `SCRU_EXT_CLK_HALF
) (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [11:0] gpio_strap_i,
  output logic [11:0] strap_pull_up_o,
  output logic [11:0] strap_pull_dn_o,
  input wire logic ext_out_a_i,
  output logic ext_out_a_o,
  output logic ext_out_a_oe_o,
  output logic ext_phy_reset_n_o,
  output logic [1:0] host_if_select_o,
  output logic autoneg_en_o,
  output logic isolate_o,
  output logic [1:0] speed_select_o,
  output logic [4:0] mgmt_addr_o,
  output logic duplex_full_o,
  output logic mac_mode_o,
  output logic memcfg_flash_o,
  output logic boot_flash_o,
  output logic boot_supported_o,
  output logic cfg_valid_o
);
  localparam int unsigned SW = $clog2(STRETCH_CYCLES + 1);
  localparam logic [SW-1:0] STRETCH_LAST = SW'(STRETCH_CYCLES - 1);

  if (STRETCH_CYCLES < 1 || CLK_HALF < 1) begin : g_chk
    $error("scru_top: STRETCH_CYCLES and CLK_HALF must be at least 1");
  end

  // ==========================================
  // strap capture
  logic [11:0] strap_reg;
  logic duplex_reg;
  logic cap_done_reg;
  logic boot_ok_reg;
  logic oe_reg;
  logic [11:0] pull_up_reg;
  logic [11:0] pull_dn_reg;
  wire cap_now = !cap_done_reg;

  // levels after the capture edge are ignored; firmware reuses the pins as leds
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      strap_reg <= `SCRU_STRAP_RST;
      duplex_reg <= `SCRU_DUPLEX_RST;
      cap_done_reg <= 1'b0;
      boot_ok_reg <= 1'b1;
      oe_reg <= 1'b0;
      pull_up_reg <= `SCRU_PULL_UP;
      pull_dn_reg <= `SCRU_PULL_DN;
    end else if (cap_now) begin
      strap_reg <= gpio_strap_i;
      duplex_reg <= ext_out_a_i;
      cap_done_reg <= 1'b1;
      boot_ok_reg <= gpio_strap_i[`SCRU_GP_BOOT] & gpio_strap_i[`SCRU_GP_MEMCFG];
      oe_reg <= gpio_strap_i[`SCRU_GP_ROLE];
    end
  end

  // ==========================================
  // apb slave, one wait state so read data leave a flop
  logic [1:0] ctrl_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [31:0] rd_mux;
  scru_seq_type seq_reg;
  scru_seq_type seq_next;
  logic clk_run_reg;
  logic ext_phy_reset_n_n_reg;

  wire access = psel_i & penable_i;
  wire first_access = access & !pready_reg;
  wire hit_ctrl = (paddr_i == `SCRU_CTRL_OFS);
  wire hit_stat = (paddr_i == `SCRU_STAT_OFS);
  wire hit_strap = (paddr_i == `SCRU_STRAP_OFS);
  wire addr_ok = hit_ctrl | hit_stat | hit_strap;
  wire wr_ctrl = access & pready_reg & pwrite_i & hit_ctrl & pstrb_i[0];
  wire [31:0] stat_word = {24'h00_0000, seq_reg, boot_ok_reg, clk_run_reg, ext_phy_reset_n_n_reg, oe_reg, cap_done_reg};
  wire [31:0] strap_word = {19'h0_0000, duplex_reg, strap_reg};

  assign rd_mux = hit_ctrl ? {30'h0000_0000, ctrl_reg} :
                  hit_stat ? stat_word :
                  hit_strap ? strap_word : 32'h0000_0000;

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
      ctrl_reg <= `SCRU_CTRL_RST;
    end else begin
      pready_reg <= first_access;
      if (first_access) begin
        prdata_reg <= pwrite_i ? 32'h0000_0000 : rd_mux;
        pslverr_reg <= !addr_ok;
      end
      if (wr_ctrl) begin
        ctrl_reg <= pwdata_i[1:0];
      end
    end
  end

  // ==========================================
  // phy reset stretch
  logic [SW-1:0] stretch_cnt_reg;
  logic [SW-1:0] stretch_cnt_next;
  wire force_rst = ctrl_reg[`SCRU_CTRL_PHYRST];
  wire stretch_end = (stretch_cnt_reg == STRETCH_LAST);

  always_comb begin
    seq_next = seq_reg;
    unique case (seq_reg)
      SEQ_HOLD: begin
        if (!force_rst) begin
          seq_next = SEQ_STRETCH;
        end
      end
      SEQ_STRETCH: begin
        if (force_rst) begin
          seq_next = SEQ_HOLD;
        end else if (stretch_end) begin
          seq_next = SEQ_RUN;
        end
      end
      SEQ_RUN: begin
        if (force_rst) begin
          seq_next = SEQ_HOLD;
        end
      end
    endcase
  end

  assign stretch_cnt_next = (seq_reg == SEQ_STRETCH && !force_rst) ? stretch_cnt_reg + 1'b1 : '0;

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      seq_reg <= SEQ_HOLD;
      stretch_cnt_reg <= '0;
      ext_phy_reset_n_n_reg <= 1'b0;
    end else begin
      seq_reg <= seq_next;
      stretch_cnt_reg <= stretch_cnt_next;
      ext_phy_reset_n_n_reg <= (seq_next == SEQ_RUN);
    end
  end

  // ==========================================
  // external phy clock, mac mode only
  logic ext_clk;
  wire clk_run_next = cap_done_reg & oe_reg & ctrl_reg[`SCRU_CTRL_CLKEN];

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      clk_run_reg <= 1'b0;
    end else begin
      clk_run_reg <= clk_run_next;
    end
  end

  scru_clk_div #(
    .HALF(CLK_HALF)
  ) u_clk_div (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .run_i(clk_run_reg),
    .clk_o(ext_clk)
  );

  // ==========================================
  // outputs
  assign prdata_o = prdata_reg;
  assign pready_o = pready_reg;
  assign pslverr_o = pslverr_reg;
  assign strap_pull_up_o = pull_up_reg;
  assign strap_pull_dn_o = pull_dn_reg;
  assign ext_out_a_o = ext_clk;
  assign ext_out_a_oe_o = oe_reg;
  assign ext_phy_reset_n_o = ext_phy_reset_n_n_reg;
  assign host_if_select_o = {strap_reg[`SCRU_GP_IFSEL1], strap_reg[`SCRU_GP_IFSEL0]};
  assign autoneg_en_o = strap_reg[`SCRU_GP_ANEG];
  assign isolate_o = strap_reg[`SCRU_GP_ISO];
  assign speed_select_o = {strap_reg[`SCRU_GP_SPD1], strap_reg[`SCRU_GP_SPD0]};
  assign mgmt_addr_o = {strap_reg[`SCRU_GP_MDA4], strap_reg[`SCRU_GP_MDA3], 3'h0};
  assign duplex_full_o = duplex_reg;
  assign mac_mode_o = strap_reg[`SCRU_GP_ROLE];
  assign memcfg_flash_o = strap_reg[`SCRU_GP_MEMCFG];
  assign boot_flash_o = strap_reg[`SCRU_GP_BOOT];
  assign boot_supported_o = boot_ok_reg;
  assign cfg_valid_o = cap_done_reg;

  // ==========================================
  // checks
  core_reset_a: assert property (
    @(posedge mclk_i) !rst_b_i |=> !ext_phy_reset_n_o && !cfg_valid_o && !ext_out_a_oe_o && !ext_out_a_o)
    else $error("logic not held in reset");

  phy_stretch_a: assert property (
    @(posedge mclk_i) disable iff (!rst_b_i)
    $rose(ext_phy_reset_n_o) |-> $past(stretch_cnt_reg) == STRETCH_LAST && $past(seq_reg) == SEQ_STRETCH)
    else $error("phy reset released before stretch ended");

  phy_hold_a: assert property (
    @(posedge mclk_i) disable iff (!rst_b_i)
    $rose(rst_b_i) |-> !ext_phy_reset_n_o ##1 !ext_phy_reset_n_o)
    else $error("phy reset not stretched past reset release");

  clk_rate_a: assert property (
    @(posedge mclk_i) disable iff (!rst_b_i)
    ($changed(ext_out_a_o) && clk_run_reg) ##1 clk_run_reg [*4] ##1 1'b1 |-> $changed(ext_out_a_o))
    else $error("phy clock half period wrong");

  clk_role_a: assert property (
    @(posedge mclk_i) disable iff (!rst_b_i)
    !mac_mode_o |-> !ext_out_a_oe_o && !ext_out_a_o && $stable(ext_out_a_o))
    else $error("phy clock active in phy mode");

  strap_capture_a: assert property (
    @(posedge mclk_i) disable iff (!rst_b_i)
    $rose(rst_b_i) |=> cfg_valid_o && strap_reg == $past(gpio_strap_i) && duplex_full_o == $past(ext_out_a_i))
    else $error("straps not latched at reset release");

  strap_frozen_a: assert property (
    @(posedge mclk_i) disable iff (!rst_b_i)
    cfg_valid_o ##1 cfg_valid_o |-> $stable(strap_reg) && $stable(duplex_full_o) && $stable(boot_supported_o))
    else $error("latched straps changed after capture");

  if_defaults_a: assert property (
    @(posedge mclk_i) !rst_b_i |=> host_if_select_o == 2'h3 && autoneg_en_o && !isolate_o &&
      strap_pull_up_o[`SCRU_GP_ANEG] && strap_pull_dn_o[`SCRU_GP_ISO])
    else $error("interface strap defaults wrong");

  boot_defaults_a: assert property (
    @(posedge mclk_i) !rst_b_i |=> mgmt_addr_o == `SCRU_MGMT_ADDR_RST && memcfg_flash_o && boot_flash_o &&
      duplex_full_o && strap_pull_up_o[`SCRU_GP_BOOT] && strap_pull_up_o[`SCRU_GP_MEMCFG])
    else $error("boot or address strap defaults wrong");

  boot_code_a: assert property (
    @(posedge mclk_i) disable iff (!rst_b_i)
    $rose(cfg_valid_o) |-> boot_supported_o ==
      ($past(gpio_strap_i[`SCRU_GP_BOOT]) && $past(gpio_strap_i[`SCRU_GP_MEMCFG])))
    else $error("boot support decode wrong");
endmodule : scru_top

/* File: test/scru_board_model.sv */
// board strap resistors and external phy model for the strap and reset unit
module scru_board_model (
  input wire logic [11:0] pull_up_i,
  input wire logic [11:0] pull_dn_i,
  input wire logic [11:0] ovr_en_i,
  input wire logic [11:0] ovr_val_i,
  input wire logic dup_en_i,
  input wire logic dup_val_i,
  input wire logic clk_pin_i,
  input wire logic clk_oe_i,
  input wire logic ext_phy_reset_n_n_i,
  output logic [11:0] gpio_o,
  output logic pin_o,
  output int phy_edges_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] float_reg = 12'h0000;
  int edges = 0;
  // ==========================================
  // strap pins
  // floating pins wander so an unpulled pin never reads as a clean level
  // odd-ns toggles keep the wander off every clock edge
  initial begin
    #1;
    forever #6 float_reg = ~float_reg;
  end
  // external resistor beats the internal pull, never a hard rail tie
  always_comb begin
    for (int b = 0; b < 12; b++) begin
      if (ovr_en_i[b]) gpio_o[b] = ovr_val_i[b];
      else if (pull_up_i[b]) gpio_o[b] = 1'b1;
      else if (pull_dn_i[b]) gpio_o[b] = 1'b0;
      else gpio_o[b] = float_reg[b];
    end
  end
  // ==========================================
  // phy clock pin and phy
  assign pin_o = clk_oe_i ? clk_pin_i : (dup_en_i ? dup_val_i : 1'b1);
  // phy counts clocks only while its reset is released
  always @(posedge pin_o) if (ext_phy_reset_n_n_i && clk_oe_i) edges <= edges + 1;
  assign phy_edges_o = edges;
endmodule : scru_board_model

/* File: test/scru_top_tb.sv */
// self-checking bench for the strap and reset unit
module scru_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int STR = 20;
  logic mclk_i = 1'b0, rst_b = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata_o;
  logic [3:0] pstrb = 4'hF;
  logic [11:0] ovr_en = 12'h000, ovr_val = 12'h000, gpio, pu, pd, lvl;
  logic dup_en = 1'b0, dup_val = 1'b0, pin, clk_o, clk_oe, prst_n, pready_o, pslverr_o;
  logic [1:0] host_if_select_o, speed_select_o;
  logic [4:0] mgmt_addr_o;
  logic autoneg_en_o, isolate_o, duplex_full_o, mac_mode_o, memcfg_flash_o, boot_flash_o;
  logic boot_supported_o, cfg_valid_o;
  logic [32:0] q[$];
  int fail_count = 0, cmp_count = 0, cyc = 0, seed = 52, i, r, edges;
  initial forever #2 mclk_i = ~mclk_i;
  scru_top #(.STRETCH_CYCLES(STR), .CLK_HALF(5)) uut (.mclk_i(mclk_i), .rst_b_i(rst_b), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .gpio_strap_i(gpio),
    .strap_pull_up_o(pu), .strap_pull_dn_o(pd), .ext_out_a_i(pin), .ext_out_a_o(clk_o),
    .ext_out_a_oe_o(clk_oe), .ext_phy_reset_n_o(prst_n), .host_if_select_o(host_if_select_o),
    .autoneg_en_o(autoneg_en_o), .isolate_o(isolate_o), .speed_select_o(speed_select_o),
    .mgmt_addr_o(mgmt_addr_o), .duplex_full_o(duplex_full_o), .mac_mode_o(mac_mode_o),
    .memcfg_flash_o(memcfg_flash_o), .boot_flash_o(boot_flash_o), .boot_supported_o(boot_supported_o),
    .cfg_valid_o(cfg_valid_o));
  scru_board_model board (.pull_up_i(pu), .pull_dn_i(pd), .ovr_en_i(ovr_en), .ovr_val_i(ovr_val),
    .dup_en_i(dup_en), .dup_val_i(dup_val), .clk_pin_i(clk_o), .clk_oe_i(clk_oe), .ext_phy_reset_n_n_i(prst_n),
    .gpio_o(gpio), .pin_o(pin), .phy_edges_o(edges));
  // ==========================================
  // checking
  task automatic check(input string nm, input logic [32:0] got, input logic [32:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask : check
  task automatic final_report;
    $display("checks %0d errors %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : final_report
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      final_report();
    end
  end
  // apb answers are paired with the oldest noted expectation
  always @(posedge mclk_i) if (psel && pen && pready_o === 1'b1) check("apb", {pslverr_o, prdata_o}, q.pop_front());
  function automatic logic [15:0] exp_cfg(input logic [11:0] l, input logic d);
    return {l[1], l[0], l[2], l[3], l[11], l[4], l[7], l[5], 3'b000, d, l[8], l[6], l[10], l[10] & l[6]};
  endfunction : exp_cfg
  // ==========================================
  // drivers
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
    @(posedge mclk_i);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    q.push_back(e);
    @(posedge mclk_i);
    pen <= 1'b1;
    // only the bench timeout ends a wait for the answer
    @(posedge mclk_i);
    while (pready_o !== 1'b1) @(posedge mclk_i);
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic wait_release(input string nm);
    int n;
    n = 0;
    do begin @(posedge mclk_i); n++; end while (prst_n !== 1'b1 && n < 100);
    check(nm, 33'(n >= STR && n <= STR + 4), 33'h1);
  endtask : wait_release
  task automatic restart(input logic [11:0] en, input logic [11:0] val, input logic de, input logic dv);
    @(posedge mclk_i);
    rst_b <= 1'b0;
    ovr_en <= en;
    ovr_val <= val;
    dup_en <= de;
    dup_val <= dv;
    repeat (10) @(posedge mclk_i);
    check("in_reset", {29'h0, cfg_valid_o, prst_n, clk_oe, clk_o}, 33'h0);
    rst_b <= 1'b1;
    wait_release("stretch");
  endtask : restart
  task automatic clk_check(input logic mac);
    int hi, rises;
    logic prev;
    hi = 0;
    rises = 0;
    repeat (3) @(posedge mclk_i);
    prev = clk_o;
    repeat (40) begin
      @(posedge mclk_i);
      hi += int'(clk_o === 1'b1);
      rises += int'(clk_o === 1'b1 && prev === 1'b0);
      prev = clk_o;
    end
    check("clk", {hi[16:0], rises[15:0]}, mac ? {17'd20, 16'd4} : 33'h0);
  endtask : clk_check
  // ==========================================
  // main sequence
  initial begin
    logic [11:0] en, val;
    logic d;
    for (i = 0; i < 5; i++) begin
      r = $random(seed);
      // the unpulled pin is always driven so its latched level is known
      en = (i > 0) ? 12'hFFF : 12'h200;
      val = r[11:0];
      val[8] = i[0];
      {val[10], val[6]} = 2'(i - 1);
      restart(en, val, i > 0, r[12]);
      lvl = (en & val) | (~en & 12'h577);
      d = (i > 0) ? r[12] : 1'b1;
      check("pulls", {9'h000, pu, pd}, {9'h000, 12'h577, 12'h888});
      check("straps_out", 33'({host_if_select_o, autoneg_en_o, isolate_o, speed_select_o, mgmt_addr_o,
        duplex_full_o, mac_mode_o, memcfg_flash_o, boot_flash_o, boot_supported_o}), 33'(exp_cfg(lvl, d)));
      check("oe", {32'h0, clk_oe}, {32'h0, lvl[8]});
      ovr_en <= 12'hFFF;
      ovr_val <= ~lvl;
      dup_en <= 1'b1;
      dup_val <= ~d;
      clk_check(lvl[8]);
      check("frozen", 33'({host_if_select_o, autoneg_en_o, isolate_o, speed_select_o, mgmt_addr_o,
        duplex_full_o, mac_mode_o, memcfg_flash_o, boot_flash_o, boot_supported_o}), 33'(exp_cfg(lvl, d)));
      if (i == 0) begin
        check("phy_edges", 33'(edges > 0), 33'h1);
        apb(1'b0, 8'h00, 32'h0, 33'h0_0000_0001);
        apb(1'b0, 8'h04, 32'h0, 33'h0_0000_009F);
        apb(1'b1, 8'h04, 32'hFFFF_FFFF, 33'h0);
        apb(1'b0, 8'h04, 32'h0, 33'h0_0000_009F);
        apb(1'b0, 8'h08, 32'h0, 33'({d, lvl}));
        apb(1'b0, 8'h40, 32'h0, 33'h1_0000_0000);
        apb(1'b1, 8'h00, 32'h0, 33'h0);
        clk_check(1'b0);
        apb(1'b1, 8'h00, 32'h3, 33'h0);
        repeat (3) @(posedge mclk_i);
        check("forced", {32'h0, prst_n}, 33'h0);
        apb(1'b1, 8'h00, 32'h1, 33'h0);
        wait_release("restretch");
      end
    end
    final_report();
  end
endmodule : scru_top_tb
